// *** hw/pllms_pkg.sv ***
// pllms_pkg: shared constants and types for the loop mode and reference select control
package pllms_pkg;

  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h33;
  localparam logic [7:0] ADDR_MASK = 8'h34;
  localparam logic [7:0] ADDR_STAT = 8'h44;
  localparam logic [7:0] RST_MODE = 8'h0F;
  localparam logic [7:0] RST_MASK = 8'h87;
  localparam logic [7:0] RST_STAT = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int HOLD_MASK_LSB = 0;
  localparam int SW_MASK_LSB = 4;
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam logic [2:0] PRIO_DISABLED = 3'h7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PLLMS_FREERUN = 2'b00,
    PLLMS_HOLDOVER = 2'b01,
    PLLMS_FORCED = 2'b10,
    PLLMS_AUTO = 2'b11
  } pllms_mode_t;

  typedef enum logic [1:0] {
    PLLMS_ST_FREE = 2'b00,
    PLLMS_ST_HOLD = 2'b01,
    PLLMS_ST_LOCK = 2'b10
  } pllms_state_t;

  // bit order matches the mask nibbles: bit 0 loss of signal
  typedef struct packed {
    logic guard_soak_timer_fail;
    logic coarse_frequency_monitor_fail;
    logic single_cycle_monitor_fail;
    logic loss_of_signal_fail;
  } pllms_fail_t;

  typedef struct packed {
    logic [1:0] refsel;
    logic external_feedback_use;
    logic [2:0] rsvd;
    pllms_mode_t mode;
  } pllms_mode_reg_t;

endpackage : pllms_pkg

// *** hw/pllms_ref_qual.sv ***
// pllms_ref_qual: per-reference availability under the failure masks
module pllms_ref_qual (
  input wire pllms_pkg::pllms_fail_t fail,
  input wire logic [2:0] prio,
  input wire logic [3:0] hold_mask,
  input wire logic [3:0] sw_mask,
  output logic usable,
  output logic hold_fail
);

  // a low mask bit hides that failure type
  logic disabled;
  assign disabled = (prio == pllms_pkg::PRIO_DISABLED);
  assign hold_fail = disabled | (|(fail & hold_mask));
  assign usable = ~disabled & ~(|(fail & sw_mask));

endmodule : pllms_ref_qual

// *** hw/pllms_sticky.sv ***
// pllms_sticky: one status bit that holds until read
module pllms_sticky (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic set_cond,
  input wire logic rd_clr,
  output logic sticky
);

  logic sticky_reg;
  logic sticky_next;

  // set wins over the read clear so an event in the read cycle is kept
  always_comb begin
    sticky_next = set_cond | (sticky_reg & ~rd_clr);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_reg <= 1'b0;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  assign sticky = sticky_reg;

endmodule : pllms_sticky

// *** hw/pllms_ctrl.sv ***
// pllms_ctrl: loop mode, reference selection, masks and sticky status
// Function
// - mode field: 00 free,01 hold,10 forced,11 auto
// - auto picks by priority; holdover when none available
// - forced mode never switches; holdover on failure
// - forced holdover keeps last selected reference
// - freerun derives outputs from oscillator only
// - feedback enable bit gates delay compensation
// - single shared feedback used whenever enabled
// - auto mode: reference field reads selection
// - forced mode: reference field selects reference
// - free and hold modes ignore reference field
// - low holdover mask bit blocks holdover entry
// - low switch mask bit blocks switching
// - status bit 0 flags holdover, unmaskable
// - status bit 1 flags lock, unmaskable
// - different priorities switch revertively; 111 disables
// - equal priorities switch non-revertively
module pllms_ctrl (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire pllms_pkg::pllms_fail_t [3:0] ref_fail,
  input wire logic [3:0][2:0] ref_priority,
  input wire logic loop_locked,
  output logic [1:0] selected_ref,
  output logic holdover_active,
  output logic oscillator_input_only,
  output logic ref_lock_active,
  output logic external_feedback_use
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  pllms_pkg::pllms_mode_reg_t mode_reg;
  pllms_pkg::pllms_mode_reg_t mode_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic stat_hold;
  logic stat_lock;
  logic stat_clr;
  // selection register sits here because the read mux shows it in auto mode
  logic [1:0] sel_reg;
  logic [1:0] sel_next;

  always_comb begin
    mode_next = mode_reg;
    mask_next = mask_reg;
    if (reg_wr && reg_addr == pllms_pkg::ADDR_MODE) begin
      mode_next = pllms_pkg::pllms_mode_reg_t'(reg_wdata);
      // the field is status in auto mode, so a write there keeps the control copy
      if (mode_next.mode == pllms_pkg::PLLMS_AUTO) begin
        mode_next.refsel = mode_reg.refsel;
      end
    end
    if (reg_wr && reg_addr == pllms_pkg::ADDR_MASK) begin
      mask_next = reg_wdata;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      pllms_pkg::ADDR_MODE: begin
        rdata_next = mode_reg;
        if (mode_reg.mode == pllms_pkg::PLLMS_AUTO) begin
          rdata_next[7:6] = sel_reg;
        end
      end
      pllms_pkg::ADDR_MASK: begin
        rdata_next = mask_reg;
      end
      pllms_pkg::ADDR_STAT: begin
        rdata_next = pllms_pkg::RST_STAT;
        rdata_next[pllms_pkg::STAT_HOLD_BIT] = stat_hold;
        rdata_next[pllms_pkg::STAT_LOCK_BIT] = stat_lock;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
    if (!reg_rd) begin
      rdata_next = rdata_reg;
    end
  end

  assign stat_clr = reg_rd && (reg_addr == pllms_pkg::ADDR_STAT);

  // ----------------------------------------
  // reference qualification
  // ----------------------------------------
  logic [3:0] usable;
  logic [3:0] hold_fail;

  for (genvar g = 0; g < 4; g++) begin : g_qual
    pllms_ref_qual u_qual (
      .fail(ref_fail[g]),
      .prio(ref_priority[g]),
      .hold_mask(mask_reg[pllms_pkg::HOLD_MASK_LSB +: 4]),
      .sw_mask(mask_reg[pllms_pkg::SW_MASK_LSB +: 4]),
      .usable(usable[g]),
      .hold_fail(hold_fail[g])
    );
  end

  // ----------------------------------------
  // selection state machine
  // ----------------------------------------
  pllms_pkg::pllms_state_t state_reg;
  pllms_pkg::pllms_state_t state_next;
  logic [1:0] best_idx;
  logic [2:0] best_prio;
  logic best_found;
  logic better_avail;

  // lowest index wins a tie, and the current one is kept on a tie below
  always_comb begin
    best_idx = 2'h0;
    best_prio = pllms_pkg::PRIO_DISABLED;
    best_found = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (usable[i] && (!best_found || ref_priority[i] < best_prio)) begin
        best_idx = 2'(i);
        best_prio = ref_priority[i];
        best_found = 1'b1;
      end
    end
    better_avail = best_found && (best_prio < ref_priority[sel_reg]);
  end

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    case (mode_reg.mode)
      pllms_pkg::PLLMS_FREERUN: begin
        state_next = pllms_pkg::PLLMS_ST_FREE;
      end
      pllms_pkg::PLLMS_HOLDOVER: begin
        state_next = pllms_pkg::PLLMS_ST_HOLD;
      end
      pllms_pkg::PLLMS_FORCED: begin
        sel_next = mode_reg.refsel;
        if (hold_fail[mode_reg.refsel]) begin
          state_next = pllms_pkg::PLLMS_ST_HOLD;
        end else begin
          state_next = pllms_pkg::PLLMS_ST_LOCK;
        end
      end
      pllms_pkg::PLLMS_AUTO: begin
        if (&hold_fail) begin
          state_next = pllms_pkg::PLLMS_ST_HOLD;
        end else if (state_reg == pllms_pkg::PLLMS_ST_LOCK && usable[sel_reg] && !better_avail) begin
          state_next = pllms_pkg::PLLMS_ST_LOCK;
        end else if (best_found) begin
          state_next = pllms_pkg::PLLMS_ST_LOCK;
          sel_next = best_idx;
        end else if (state_reg != pllms_pkg::PLLMS_ST_LOCK) begin
          // no reference usable for switching: wait in holdover rather than pick blindly
          state_next = pllms_pkg::PLLMS_ST_HOLD;
        end
      end
      default: begin
        state_next = pllms_pkg::PLLMS_ST_FREE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= pllms_pkg::pllms_mode_reg_t'(pllms_pkg::RST_MODE);
      mask_reg <= pllms_pkg::RST_MASK;
      rdata_reg <= 8'h00;
      state_reg <= pllms_pkg::PLLMS_ST_FREE;
      sel_reg <= 2'h0;
    end else begin
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      sel_reg <= sel_next;
    end
  end

  // ----------------------------------------
  // sticky status
  // ----------------------------------------
  pllms_sticky u_hold_sticky (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set_cond(holdover_active),
    .rd_clr(stat_clr),
    .sticky(stat_hold)
  );

  pllms_sticky u_lock_sticky (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set_cond(ref_lock_active),
    .rd_clr(stat_clr),
    .sticky(stat_lock)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign selected_ref = sel_reg;
  assign holdover_active = (state_reg == pllms_pkg::PLLMS_ST_HOLD);
  assign oscillator_input_only = (state_reg == pllms_pkg::PLLMS_ST_FREE);
  assign ref_lock_active = (state_reg == pllms_pkg::PLLMS_ST_LOCK) && loop_locked;
  // one shared feedback path, so no per-loop source select here
  assign external_feedback_use = mode_reg.external_feedback_use;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  freerun_osc_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_FREERUN |=> oscillator_input_only && !holdover_active)
    else $error("freerun mode did not select oscillator");

  hold_keeps_sel_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_HOLDOVER |=> holdover_active && selected_ref == $past(sel_reg))
    else $error("forced holdover changed selection");

  forced_lock_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_FORCED && !hold_fail[mode_reg.refsel]
    |=> state_reg == pllms_pkg::PLLMS_ST_LOCK && selected_ref == $past(mode_reg.refsel))
    else $error("forced reference not locked");

  forced_fail_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_FORCED && hold_fail[mode_reg.refsel] |=> holdover_active)
    else $error("forced reference failure did not hold over");

  auto_none_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO && (&hold_fail) |=> holdover_active)
    else $error("auto mode kept lock with no reference");

  auto_revert_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO && !(&hold_fail) && better_avail
    |=> selected_ref == $past(best_idx))
    else $error("auto mode missed better priority reference");

  auto_stay_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO && !(&hold_fail) && state_reg == pllms_pkg::PLLMS_ST_LOCK
    && usable[sel_reg] && !better_avail |=> $stable(selected_ref))
    else $error("auto mode switched between equal priorities");

  fb_write_a: assert property (
    reg_wr && reg_addr == pllms_pkg::ADDR_MODE |=> external_feedback_use == $past(reg_wdata[5]))
    else $error("feedback enable not taken from write");

  refsel_status_a: assert property (
    reg_rd && reg_addr == pllms_pkg::ADDR_MODE && mode_reg.mode == pllms_pkg::PLLMS_AUTO
    |=> reg_rdata[7:6] == $past(sel_reg))
    else $error("reference field did not show selection");

  hold_sticky_a: assert property (
    holdover_active |=> stat_hold)
    else $error("holdover sticky bit not set");

  lock_sticky_a: assert property (
    ref_lock_active ##1 !ref_lock_active && !stat_clr |=> stat_lock)
    else $error("lock sticky bit lost without read");

  read_clear_a: assert property (
    stat_clr && !holdover_active |=> !stat_hold)
    else $error("holdover sticky bit not cleared by read");

  mask_block_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_FORCED && mask_reg[3:0] == 4'h0
    && ref_priority[mode_reg.refsel] != pllms_pkg::PRIO_DISABLED |=> !holdover_active)
    else $error("masked failure caused holdover");

  switch_block_a: assert property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO && mask_reg[7:4] == 4'h0 && !(&hold_fail)
    && state_reg == pllms_pkg::PLLMS_ST_LOCK && ref_priority[sel_reg] != pllms_pkg::PRIO_DISABLED
    && !better_avail |=> $stable(selected_ref))
    else $error("masked failure caused a switch");

  auto_switch_c: cover property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO && state_reg == pllms_pkg::PLLMS_ST_LOCK ##1 $changed(sel_reg));
  auto_hold_c: cover property (
    mode_reg.mode == pllms_pkg::PLLMS_AUTO ##1 $rose(holdover_active));
  forced_hold_c: cover property (
    mode_reg.mode == pllms_pkg::PLLMS_FORCED && hold_fail[mode_reg.refsel] ##1 holdover_active);
  sticky_read_c: cover property (stat_clr && stat_lock);
  mask_hold_c: cover property (
    mode_reg.mode == pllms_pkg::PLLMS_FORCED && mask_reg[3:0] == 4'h0 && ref_fail[mode_reg.refsel] != 4'h0);

endmodule : pllms_ctrl

// *** verif/pllms_far_model.sv ***
// pllms_far_model: reference monitors and lock detector beside the control block
module pllms_far_model #(
  parameter int LOCK_DELAY = 3
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pllms_pkg::pllms_fail_t [3:0] cmd_fail,
  input wire logic [3:0][2:0] cmd_prio,
  input wire logic holdover_active,
  input wire logic oscillator_input_only,
  output pllms_pkg::pllms_fail_t [3:0] ref_fail,
  output logic [3:0][2:0] ref_priority,
  output logic loop_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  int lock_cnt;
  // ----------------------------------------
  // monitors and lock detector
  // ----------------------------------------
  // lock drops on the next edge on holdover or freerun, acquisition takes LOCK_DELAY+1 edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_fail <= '0;
      ref_priority <= {3'h3, 3'h2, 3'h1, 3'h0};
      lock_cnt <= 0;
      loop_locked <= 1'b0;
    end else begin
      ref_fail <= cmd_fail;
      ref_priority <= cmd_prio;
      if (holdover_active || oscillator_input_only) begin
        lock_cnt <= 0;
        loop_locked <= 1'b0;
      end else if (lock_cnt < LOCK_DELAY) begin
        lock_cnt <= lock_cnt + 1;
      end else begin
        loop_locked <= 1'b1;
      end
    end
  end
endmodule : pllms_far_model

// *** verif/tb.sv ***
// tb: scenarios for the loop mode and reference select control
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  pllms_pkg::pllms_fail_t [3:0] ref_fail;
  pllms_pkg::pllms_fail_t [3:0] cmd_fail = '0;
  logic [3:0][2:0] ref_priority;
  logic [3:0][2:0] cmd_prio = {3'h3, 3'h2, 3'h1, 3'h0};
  logic loop_locked;
  logic [1:0] selected_ref;
  logic holdover_active;
  logic oscillator_input_only;
  logic ref_lock_active;
  logic external_feedback_use;
  logic [7:0] v;
  int n_fail = 0;
  int comparisons = 0;

  pllms_ctrl uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_fail(ref_fail),
    .ref_priority(ref_priority), .loop_locked(loop_locked), .selected_ref(selected_ref),
    .holdover_active(holdover_active), .oscillator_input_only(oscillator_input_only),
    .ref_lock_active(ref_lock_active), .external_feedback_use(external_feedback_use));
  pllms_far_model #(.LOCK_DELAY(3)) far (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_fail(cmd_fail),
    .cmd_prio(cmd_prio), .holdover_active(holdover_active), .oscillator_input_only(oscillator_input_only),
    .ref_fail(ref_fail), .ref_priority(ref_priority), .loop_locked(loop_locked));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  // strobes last exactly one edge, so a following call never reasserts in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic wait_sel(input logic [1:0] exp);
    int i;
    for (i = 0; i < 20 && selected_ref !== exp; i++) begin
      idle(1);
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    check("selected_ref", {6'h00, selected_ref}, {6'h00, exp});
  endtask : wait_sel

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    idle(4);
    rd(8'h34, v);
    check("mask reset", v, 8'h87);
    rd(8'h33, v);
    check("mode reset auto", v, 8'h0F);
    wr(8'h50, 8'hFF);
    rd(8'h50, v);
    check("unmapped", v, 8'h00);
  endtask : t_regs

  task automatic t_revert();
    wr(8'h34, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      cmd_fail[0] = 4'(1 << k);
      wait_sel(2'h1);
      if (k == 0) begin
        rd(8'h33, v);
        check("refsel status", v, 8'h4F);
      end
      cmd_fail[0] = 4'h0;
      wait_sel(2'h0);
    end
    cmd_prio[0] = pllms_pkg::PRIO_DISABLED;
    wait_sel(2'h1);
    cmd_prio = {3'h3, 3'h2, 3'h0, 3'h0};
    idle(6);
    check("equal prio stay", {6'h00, selected_ref}, 8'h01);
    cmd_prio[1] = 3'h1;
    wait_sel(2'h0);
  endtask : t_revert

  task automatic t_swmask();
    for (int k = 0; k < 4; k++) begin
      wr(8'h34, {4'hF & ~4'(1 << k), 4'hF});
      cmd_fail[0] = 4'(1 << k);
      idle(6);
      check("switch masked", {6'h00, selected_ref}, 8'h00);
      cmd_fail[0] = 4'h0;
    end
    wr(8'h34, 8'h0F);
    cmd_fail[0] = 4'hF;
    idle(6);
    check("all switch masked", {6'h00, selected_ref}, 8'h00);
    cmd_fail[0] = 4'h0;
  endtask : t_swmask

  task automatic t_hold();
    wr(8'h34, 8'hFF);
    cmd_fail = {4{4'h1}};
    idle(5);
    check("all failed hold", {7'h00, holdover_active}, 8'h01);
    cmd_fail[3] = 4'h0;
    wait_sel(2'h3);
    check("left hold", {7'h00, holdover_active}, 8'h00);
    wr(8'h34, 8'hF0);
    cmd_fail[3] = 4'h1;
    idle(5);
    check("hold masked", {7'h00, holdover_active}, 8'h00);
    cmd_fail = '0;
    wr(8'h34, 8'hFF);
    wait_sel(2'h0);
  endtask : t_hold

  task automatic t_forced();
    for (int r = 0; r < 4; r++) begin
      wr(8'h33, {2'(r), 6'h02});
      wait_sel(2'(r));
    end
    cmd_fail[3] = 4'h1;
    idle(5);
    check("forced fail hold", {7'h00, holdover_active}, 8'h01);
    check("forced no switch", {6'h00, selected_ref}, 8'h03);
    rd(8'h33, v);
    check("forced readback", v, 8'hC2);
    wr(8'h34, 8'hF0);
    idle(2);
    check("forced hold masked", {7'h00, holdover_active}, 8'h00);
    check("forced masked ref", {6'h00, selected_ref}, 8'h03);
    wr(8'h34, 8'hFF);
    cmd_fail[3] = 4'h0;
    wr(8'h33, 8'h22);
    idle(1);
    check("feedback on", {7'h00, external_feedback_use}, 8'h01);
    wr(8'h33, 8'h82);
    idle(1);
    check("feedback off", {7'h00, external_feedback_use}, 8'h00);
    wait_sel(2'h2);
  endtask : t_forced

  task automatic t_hold_free();
    wr(8'hFF & 8'hC1, 8'hC1);
    wr(8'h33, 8'hC1);
    idle(4);
    check("forced holdover", {7'h00, holdover_active}, 8'h01);
    check("keeps last ref", {6'h00, selected_ref}, 8'h02);
    wr(8'h33, 8'hC0);
    idle(4);
    check("freerun", {6'h00, oscillator_input_only, holdover_active}, 8'h02);
    check("freerun no lock", {7'h00, ref_lock_active}, 8'h00);
  endtask : t_hold_free

  task automatic t_sticky();
    rd(8'h44, v);
    check("sticky both", v, 8'h03);
    rd(8'h44, v);
    check("sticky cleared", v, 8'h00);
    wr(8'h33, 8'h0F);
    wait_sel(2'h0);
    idle(8);
    check("locked", {7'h00, ref_lock_active}, 8'h01);
    wr(8'h44, 8'hFF);
    rd(8'h44, v);
    check("lock persists", v, 8'h02);
    rd(8'h44, v);
    check("lock still", v, 8'h02);
  endtask : t_sticky

  initial begin
    idle(2);
    check("reset state", {5'h00, oscillator_input_only, selected_ref}, 8'h04);
    check("reset feedback", {7'h00, external_feedback_use}, 8'h00);
    idle(3);
    rst_b = 1'b1;
    t_regs();
    t_revert();
    t_swmask();
    t_hold();
    t_forced();
    t_hold_free();
    t_sticky();
    print_verdict();
  end
endmodule : tb
